// file: src/stc_cal.sv
// How it works
// RQ1: config bits 3:2 pick 4, 16, 64 or 256 averages; more averages mean a longer, steadier calibration.
// RQ2: config bits 1:0 pick 4, 16, 64 or 256 cycles per accumulation.
// RQ3: the sysref source must keep its period within 128, 1664, 7808 or 32384 cycles for codes 0 to 3.
// RQ4: a sysref period beyond the selected limit fails the calibration with no valid result.
// RQ5: a calibration ends within 384 * 19 * 4^(avg + acc + 2) cycles or is failed.
// RQ6: a longer accumulation averages over more samples and so gives a steadier delay code.
// RQ7: the done flag, status bit 17, is one only while enabled and after the sequence completed.
// RQ8: the delay value in status bits 16:0 is shown only while the done flag is one.
// RQ9: delay bit 16 is the clock inversion, bits 15:8 the coarse code and bits 7:0 the fine code.
// RQ10: the configuration register resets to 0x05.
// RQ11: a zero-to-one change of the enable starts the calibration.
// RQ12: software writes the configuration before it sets the enable.
// RQ13: while enabled the applied delay is the computed one and the manual setting is ignored; the code holds the last manual value unless done.
// RQ14: clearing the enable drops the done flag until a new calibration completes.
`timescale 1ns/1ps
`default_nettype none
module stc_cal
    import stc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // register port
    input wire logic [9:0] REG_ADDR,
    input wire logic REG_WE,
    input wire logic [7:0] REG_WDATA,
    output logic [23:0] REG_RDATA,
    // enable and manual delay from neighbouring registers
    input wire logic CAL_ENABLE,
    input wire logic [16:0] TAD_MANUAL,
    // timing reference
    input wire logic SYSREF,
    // delay applied to the sampling clock and failure indication
    output logic [16:0] TAD_OUT,
    output logic CAL_FAILED
);
    typedef struct packed {
        stc_state_t st;
        logic en_prev;
        logic [7:0] cfg;
        logic [1:0] avg_sel;
        logic [1:0] acc_sel;
        logic [16:0] win_cnt;
        logic [16:0] high_sum;
        logic [7:0] edge_cnt;
        logic armed;
        logic [16:0] result;
        logic [28:0] elapsed;
        logic [23:0] rdata;
        logic [16:0] tad;
    } stc_cal_state_t;

    stc_cal_state_t s_reg, s_next;
    logic [15:0] limit;
    logic [4:0] win_log2;
    logic [16:0] win_len;
    logic [28:0] max_cal_duration;
    logic mon_restart;
    logic sys_rise;
    logic too_long;
    logic start;
    logic cal_done_flag;
    logic [23:0] status_word;
    logic [24:0] fine_wide;

    // period limit for the accumulation code in use
    always_comb
    begin
        case (s_reg.acc_sel)
            2'h0: limit = STC_PERIOD_LIMIT_0;  // RQ3
            2'h1: limit = STC_PERIOD_LIMIT_1;
            2'h2: limit = STC_PERIOD_LIMIT_2;
            default: limit = STC_PERIOD_LIMIT_3;
        endcase
    end

    // window is averages times accumulation length, both powers of four
    assign win_log2 = 5'(2 * (s_reg.avg_sel + 1) + 2 * (s_reg.acc_sel + 1));  // RQ1 RQ2
    assign win_len = 17'(17'h1 << win_log2);
    assign max_cal_duration = 29'(STC_DURATION_BASE <<
        (2 * (s_reg.avg_sel + s_reg.acc_sel + STC_DURATION_EXP_OFFSET)));  // RQ5

    assign start = CAL_ENABLE & ~s_reg.en_prev;  // RQ11
    assign mon_restart = start;
    assign cal_done_flag = CAL_ENABLE && s_reg.st == STC_DONE;  // RQ7 RQ14
    // high samples over the window, scaled to the fine code
    assign fine_wide = 25'({s_reg.high_sum, 8'h00} >> win_log2);  // RQ6

    // status word: value shown only alongside the done flag
    always_comb
    begin
        status_word = '0;
        status_word[STC_DONE_BIT] = cal_done_flag;
        if (cal_done_flag)
        begin
            status_word[STC_RESULT_W-1:0] = s_reg.result;  // RQ8
        end
    end

    stc_period_mon #(
        .CNT_W(16)
    ) u_mon (
        .CLK(CLK),
        .RST_N(RST_N),
        .restart(mon_restart),
        .limit(limit),
        .sysref(SYSREF),
        .rise(sys_rise),
        .too_long(too_long)
    );

    // sequence, register file and applied delay
    always_comb
    begin
        s_next = s_reg;
        s_next.en_prev = CAL_ENABLE;
        if (REG_WE && REG_ADDR == STC_ADDR_CAL_CONFIG)
        begin
            s_next.cfg = REG_WDATA;
        end
        if (s_reg.st != STC_IDLE)
        begin
            s_next.elapsed = s_reg.elapsed + 1'b1;
        end
        case (s_reg.st)
            STC_IDLE:
            begin
                if (start)
                begin
                    s_next.st = STC_WAIT_EDGE;
                    s_next.avg_sel = s_reg.cfg[STC_AVG_LSB +: 2];  // RQ12
                    s_next.acc_sel = s_reg.cfg[STC_ACC_LSB +: 2];
                    s_next.elapsed = '0;
                    s_next.armed = 1'b0;
                end
            end
            STC_WAIT_EDGE:
            begin
                if (too_long)
                begin
                    s_next.st = STC_FAIL;  // RQ4
                end
                else if (sys_rise && !s_reg.armed)
                begin
                    s_next.armed = 1'b1;  // RQ4 watch one whole period before running
                end
                else if (sys_rise)
                begin
                    s_next.st = STC_RUN;
                    s_next.win_cnt = '0;
                    s_next.high_sum = '0;
                    s_next.edge_cnt = '0;
                end
            end
            STC_RUN:
            begin
                s_next.win_cnt = s_reg.win_cnt + 1'b1;
                s_next.high_sum = s_reg.high_sum + 17'(SYSREF);
                s_next.edge_cnt = s_reg.edge_cnt + 8'(sys_rise);
                if (too_long || s_reg.elapsed >= max_cal_duration)
                begin
                    s_next.st = STC_FAIL;  // RQ4 RQ5
                end
                else if (s_reg.win_cnt == win_len - 17'h1)
                begin
                    s_next.st = STC_DONE;
                    s_next.result[STC_INV_BIT] = s_reg.high_sum >= 17'(win_len >> 1);  // RQ9
                    s_next.result[STC_COARSE_LSB +: 8] = s_reg.edge_cnt;
                    s_next.result[STC_FINE_LSB +: STC_FINE_BITS] =
                        (fine_wide > 25'hFF) ? 8'hFF : fine_wide[7:0];
                end
            end
            default:
            begin
            end
        endcase
        if (!CAL_ENABLE)
        begin
            s_next.st = STC_IDLE;  // RQ14
        end
        // applied delay takes the result in the done state while enabled, holds in other enabled states, and takes the manual delay while disabled
        if (CAL_ENABLE)
        begin
            if (s_reg.st == STC_DONE)
            begin
                s_next.tad = s_reg.result;  // RQ13
            end
        end
        else
        begin
            s_next.tad = TAD_MANUAL;
        end
        // read data, one cycle behind the address
        if (REG_ADDR == STC_ADDR_CAL_CONFIG)
        begin
            s_next.rdata = {16'h0000, s_reg.cfg};
        end
        else if (REG_ADDR == STC_ADDR_CAL_RESULT_STATUS)
        begin
            s_next.rdata = status_word;
        end
        else
        begin
            s_next.rdata = '0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_reg <= '0;
            s_reg.st <= STC_IDLE;
            s_reg.cfg <= STC_CAL_CONFIG_RESET;  // RQ10
            s_reg.avg_sel <= 2'h1;
            s_reg.acc_sel <= 2'h1;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign REG_RDATA = s_reg.rdata;
    assign TAD_OUT = s_reg.tad;
    assign CAL_FAILED = s_reg.st == STC_FAIL;

    // checks
    AST_CFG_RESET: assert property (@(posedge CLK) $rose(RST_N) |-> s_reg.cfg == 8'h05)  // RQ10
        else $error("config not at reset value");
    AST_START: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_reg.st == STC_IDLE && CAL_ENABLE && !s_reg.en_prev) |=> s_reg.st == STC_WAIT_EDGE)  // RQ11
        else $error("rising enable did not start calibration");
    AST_DONE_NEEDS_EN: assert property (@(posedge CLK) disable iff (!RST_N)
        !CAL_ENABLE |=> !s_reg.rdata[17] || $past(REG_ADDR) != STC_ADDR_CAL_RESULT_STATUS)  // RQ7
        else $error("done flag shown while disabled");
    AST_CLEAR_DROPS: assert property (@(posedge CLK) disable iff (!RST_N)
        $fell(CAL_ENABLE) |-> ##1 s_reg.st == STC_IDLE)  // RQ14
        else $error("state kept after enable cleared");
    AST_VALUE_GATED: assert property (@(posedge CLK) disable iff (!RST_N)
        (!cal_done_flag && REG_ADDR == STC_ADDR_CAL_RESULT_STATUS) |=> REG_RDATA[16:0] == 17'h0)  // RQ8
        else $error("delay value shown without done");
    AST_FAIL_PERIOD: assert property (@(posedge CLK) disable iff (!RST_N)
        (CAL_ENABLE && too_long && s_reg.st == STC_RUN) |=> s_reg.st == STC_FAIL)  // RQ4
        else $error("long period did not fail");
    AST_BOUND: assert property (@(posedge CLK) disable iff (!RST_N)
        s_reg.st inside {STC_WAIT_EDGE, STC_RUN} |-> s_reg.elapsed <= max_cal_duration)  // RQ5
        else $error("calibration ran over its bound");
    AST_MANUAL: assert property (@(posedge CLK) disable iff (!RST_N)
        (CAL_ENABLE && s_reg.en_prev && $stable(s_reg.st) && s_reg.st != STC_DONE) |=> $stable(TAD_OUT))  // RQ13
        else $error("manual delay leaked while enabled");
    AST_FIELDS: assert property (@(posedge CLK) disable iff (!RST_N)
        (s_reg.st == STC_RUN && s_next.st == STC_DONE) |=> s_reg.result[15:8] == $past(s_reg.edge_cnt))  // RQ9
        else $error("coarse code misplaced");
endmodule
`default_nettype wire

// file: shared/stc_pkg.sv
package stc_pkg;
    // register map and layout of the configuration and status words
    localparam logic [9:0] STC_ADDR_CAL_CONFIG = 10'h2B1;
    localparam logic [9:0] STC_ADDR_CAL_RESULT_STATUS = 10'h2B2;
    localparam logic [7:0] STC_CAL_CONFIG_RESET = 8'h05;
    localparam int STC_AVG_LSB = 2;
    localparam int STC_ACC_LSB = 0;
    localparam int STC_DONE_BIT = 17;
    localparam int STC_INV_BIT = 16;
    localparam int STC_COARSE_LSB = 8;
    localparam int STC_FINE_LSB = 0;
    localparam int STC_RESULT_W = 17;
    localparam int STC_STATUS_W = 24;
    // longest allowed sysref period per accumulation code, sampling-clock cycles
    localparam logic [15:0] STC_PERIOD_LIMIT_0 = 16'd128;
    localparam logic [15:0] STC_PERIOD_LIMIT_1 = 16'd1664;
    localparam logic [15:0] STC_PERIOD_LIMIT_2 = 16'd7808;
    localparam logic [15:0] STC_PERIOD_LIMIT_3 = 16'd32384;
    // calibration duration bound: base * 4^(avg + acc + 2)
    localparam logic [31:0] STC_DURATION_BASE = 32'd7296;  // 384 * 19
    localparam int STC_DURATION_EXP_OFFSET = 2;
    // fine code is the high fraction scaled to this many bits
    localparam int STC_FINE_BITS = 8;

    typedef enum logic [2:0] {STC_IDLE, STC_WAIT_EDGE, STC_RUN, STC_DONE, STC_FAIL} stc_state_t;
endpackage

// file: src/stc_period_mon.sv
`timescale 1ns/1ps
`default_nettype none
module stc_period_mon
    import stc_pkg::*;
#(
    parameter int CNT_W = 16
)(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // control
    input wire logic restart,
    input wire logic [CNT_W-1:0] limit,
    // sysref sample
    input wire logic sysref,
    // results
    output logic rise,
    output logic too_long
);
    typedef struct packed {
        logic prev;
        logic [CNT_W-1:0] cnt;
        logic over;
    } stc_mon_state_t;

    stc_mon_state_t s_reg, s_next;

    // edge seen in the current sample
    assign rise = sysref & ~s_reg.prev;
    assign too_long = s_reg.over;

    // count cycles since restart or the last rising edge, saturating
    always_comb
    begin
        s_next = s_reg;
        s_next.prev = sysref;
        if (restart)
        begin
            s_next.cnt = '0;
            s_next.over = 1'b0;
        end
        else if (rise)
        begin
            s_next.cnt = '0;
        end
        else if (s_reg.cnt != '1)
        begin
            s_next.cnt = s_reg.cnt + 1'b1;
        end
        if (!restart && !rise && s_reg.cnt >= limit)
        begin
            s_next.over = 1'b1;  // period has run past the limit
        end
    end

    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end
endmodule
`default_nettype wire

// file: bench/stc_sysref_src.sv
`timescale 1ns/1ps
`default_nettype none
module stc_sysref_src
    import stc_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // reference period in sampling-clock cycles
    input wire logic [15:0] PERIOD,
    // reference output
    output var logic SYSREF
);
    logic [15:0] cnt_reg;
    // periodic reference, high for the first half of each period
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            cnt_reg <= 16'h0000;
            SYSREF <= 1'b0;
        end
        else
        begin
            cnt_reg <= (cnt_reg >= PERIOD - 16'h0001) ? 16'h0000 : cnt_reg + 16'h0001;
            SYSREF <= (cnt_reg < (PERIOD >> 1));
        end
    end
endmodule
`default_nettype wire

// file: bench/stc_cal_test.sv
`timescale 1ns/1ps
`default_nettype none
module stc_cal_test
    import stc_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [9:0] reg_addr = STC_ADDR_CAL_RESULT_STATUS;
    logic reg_we = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [23:0] reg_rdata;
    logic cal_enable = 1'b0;
    logic [16:0] tad_manual = 17'h1A5C3;
    logic sysref;
    logic [15:0] period = 16'h0064;
    logic [16:0] tad_out;
    logic cal_failed;
    logic [23:0] d;
    int error_cnt = 0;
    int n_compared = 0;
    int cycles = 0;

    // clock
    always #20 clk = ~clk;

    // reference source and block under test
    stc_sysref_src u_src (.CLK(clk), .RST_N(rst_n), .PERIOD(period), .SYSREF(sysref));
    stc_cal u_dut (.CLK(clk), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WE(reg_we), .REG_WDATA(reg_wdata),
        .REG_RDATA(reg_rdata), .CAL_ENABLE(cal_enable), .TAD_MANUAL(tad_manual), .SYSREF(sysref),
        .TAD_OUT(tad_out), .CAL_FAILED(cal_failed));

    task automatic complete_run;
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // hang guard
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            complete_run;
        end
    end

    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_we <= 1'b1;
        reg_wdata <= v;
        @(posedge clk);
        reg_we <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, output logic [23:0] v);
        @(posedge clk);
        reg_addr <= a;
        @(posedge clk);
        #1;
        v = reg_rdata;
    endtask

    // one calibration: configure, enable, wait for done or failure, disable
    task automatic cal_run(input logic [1:0] avg, input logic [1:0] acc, input int per, input bit ok);
        int w;
        int n;
        logic [23:0] v;
        w = 4 ** (int'(avg) + int'(acc) + 2);
        n = 0;
        period <= per[15:0];
        wr(STC_ADDR_CAL_CONFIG, {4'h0, avg, acc});
        rd(STC_ADDR_CAL_CONFIG, v);
        check("config", v, {20'h00000, avg, acc});
        @(posedge clk);
        reg_addr <= STC_ADDR_CAL_RESULT_STATUS;
        cal_enable <= 1'b1;
        while (reg_rdata[17] !== 1'b1 && cal_failed !== 1'b1 && n < w + 2 * per + 16)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("done", 24'(reg_rdata[17]), 24'(ok));
        check("failed", 24'(cal_failed), 24'(!ok));
        if (ok)
        begin
            check("duration", 24'(n >= w && n <= w + 2 * per + 16 && n <= 7296 * w), 24'h000001);
            repeat (2) @(posedge clk);
            #1;
            check("applied delay", 24'(tad_out), 24'(reg_rdata[16:0]));
            check("status reserved", 24'(reg_rdata[23:18]), 24'h000000);
        end
        else
            check("delay kept", 24'(tad_out), 24'(tad_manual));
        @(posedge clk);
        cal_enable <= 1'b0;
        tad_manual <= tad_manual ^ 17'h1FFFF;
        repeat (3) @(posedge clk);
        #1;
        check("done cleared", 24'(reg_rdata[17]), 24'h000000);
        check("manual delay", 24'(tad_out), 24'(tad_manual));
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        rd(STC_ADDR_CAL_CONFIG, d);
        check("config reset", d, 24'h000005);
        rd(STC_ADDR_CAL_RESULT_STATUS, d);
        check("status reset", d, 24'h000000);
        check("manual delay", 24'(tad_out), 24'(tad_manual));
        wr(STC_ADDR_CAL_CONFIG, 8'hF0);
        rd(STC_ADDR_CAL_CONFIG, d);
        check("config reserved", d, 24'h0000F0);
        wr(STC_ADDR_CAL_RESULT_STATUS, 8'hFF);
        rd(STC_ADDR_CAL_RESULT_STATUS, d);
        check("status read only", d, 24'h000000);
        rd(10'h3FF, d);
        check("unmapped", d, 24'h000000);
        for (int a = 0; a < 4; a++)
            cal_run(a[1:0], 2'h0, 100, 1'b1);
        for (int c = 1; c < 4; c++)
            cal_run(2'h0, c[1:0], 100, 1'b1);
        cal_run(2'h0, 2'h0, 200, 1'b0);
        cal_run(2'h1, 2'h3, 3000, 1'b1);
        complete_run;
    end
endmodule
`default_nettype wire
